// File: hw/ohs_pkg.sv
// Purpose: shared types and constants for the overcurrent hiccup sequencer
// Assumes: one channel, pwm cycle marked by a one-cycle enable on ref_clk
// Notes: counts are defaults; the top module exposes them as parameters
package ohs_pkg;
	localparam int unsigned OC_TRIP_CYCLES = 7;
	localparam int unsigned HICCUP_CYCLES = 7;
	localparam int unsigned SS_CHARGE_PWM = 64;
	localparam int unsigned SS_DISCH_PWM = 64;
	localparam int unsigned CNT_W = 8;

	typedef enum {
		OHS_ST_RUN,
		OHS_ST_CHARGE,
		OHS_ST_DISCHARGE
	} ohs_state_t;

	// analog comparator results for one pwm cycle
	typedef struct packed {
		logic over_limit;
		logic track_masked;
		logic undervolt;
		logic in_regulation;
	} ohs_sense_t;

	// drive side of the channel
	typedef struct packed {
		logic hi_drive;
		logic lo_drive;
		logic ss_charge;
		logic ss_discharge;
	} ohs_drive_t;
endpackage : ohs_pkg

// File: hw/ohs_sync3.sv
// Purpose: three-flop synchroniser with agreement filter for pin inputs
// Assumes: single ref_clk domain
// Notes: output changes only once stages two and three agree
`timescale 1ns/1ns
module ohs_sync3 #(
	parameter int unsigned W = 1
) (
	input wire logic ref_clk, // clock
	input wire logic reset_n, // sync reset, active low
	input wire logic [W-1:0] d, // asynchronous inputs
	output logic [W-1:0] q // filtered result
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_nxt;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			assign q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q[i];
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q <= q_nxt;
		end
	end
endmodule : ohs_sync3

// File: hw/ohs_sequencer.sv
// Purpose: overcurrent hiccup sequencer for one buck channel
// Assumes: pwm_cycle_en pulses once per switching cycle; comparators are pins
`timescale 1ns/1ns
module ohs_sequencer #(
	parameter int unsigned OC_TRIP = ohs_pkg::OC_TRIP_CYCLES,
	parameter int unsigned HICCUPS = ohs_pkg::HICCUP_CYCLES,
	parameter int unsigned CHG_PWM = ohs_pkg::SS_CHARGE_PWM,
	parameter int unsigned DIS_PWM = ohs_pkg::SS_DISCH_PWM
) (
	input wire logic ref_clk, // 125 MHz clock
	input wire logic reset_n, // sync reset, active low
	input wire logic pwm_cycle_en, // one pulse per switching cycle
	input wire logic pwm_on, // modulator on-time request, same clock
	input wire ohs_pkg::ohs_sense_t sense_pin, // raw comparator pins
	output ohs_pkg::ohs_drive_t drive, // switch and soft-start drive
	output logic power_good_output, // high while running, regulated and unmasked
	output logic uv_fault, // registered undervoltage fault flag
	output logic hiccup_active, // high during hiccup
	output logic hiccup_entry // one-cycle pulse on hiccup entry
);
	localparam int unsigned CW = ohs_pkg::CNT_W;
	// CW must hold the largest count; a narrower width truncates the compare value and shortens a phase

	// ------------------------------------------------------------
	// input synchronisation
	// ------------------------------------------------------------
	// pins reach the logic three to four clocks late, short against one switching period
	ohs_pkg::ohs_sense_t sense;
	ohs_sync3 #(.W($bits(ohs_pkg::ohs_sense_t))) u_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.d(sense_pin),
		.q(sense)
	);

	// ------------------------------------------------------------
	// state and counters
	// ------------------------------------------------------------
	ohs_pkg::ohs_state_t state_r;
	ohs_pkg::ohs_state_t state_nxt;
	logic [CW-1:0] oc_cnt_r;
	logic [CW-1:0] oc_cnt_nxt;
	logic [CW-1:0] hic_cnt_r;
	logic [CW-1:0] hic_cnt_nxt;
	logic [CW-1:0] ss_cnt_r;
	logic [CW-1:0] ss_cnt_nxt;
	logic pulse_cut_r;
	logic pulse_cut_nxt;
	logic pg_r;
	logic uv_r;
	logic entry_r;
	ohs_pkg::ohs_drive_t drive_r;
	ohs_pkg::ohs_drive_t drive_nxt;

	wire logic running = (state_r == ohs_pkg::OHS_ST_RUN);
	// trip no earlier than the cycle boundary that completes the seventh overcurrent cycle, and only while unmasked
	wire logic oc_cycle = pwm_cycle_en && sense.over_limit;
	wire logic trip = running && oc_cycle && !sense.track_masked
		&& (oc_cnt_r == CW'(OC_TRIP - 1));
	wire logic ss_done_chg = pwm_cycle_en && (ss_cnt_r == CW'(CHG_PWM - 1));
	wire logic ss_done_dis = pwm_cycle_en && (ss_cnt_r == CW'(DIS_PWM - 1));
	wire logic last_hiccup = (hic_cnt_r == CW'(HICCUPS - 1));

	// ------------------------------------------------------------
	// overcurrent counting
	// ------------------------------------------------------------
	// while masked the count parks at its last step, so lifting the mask under
	// a standing overload trips at the very next cycle boundary
	always_comb begin
		oc_cnt_nxt = oc_cnt_r;
		if (!running || trip) begin
			oc_cnt_nxt = '0;
		end else if (pwm_cycle_en) begin
			if (!sense.over_limit) begin
				oc_cnt_nxt = '0;
			end else if (oc_cnt_r != CW'(OC_TRIP - 1)) begin
				oc_cnt_nxt = oc_cnt_r + CW'(1);
			end
		end
	end

	// ------------------------------------------------------------
	// hiccup sequence
	// ------------------------------------------------------------
	// one charge plus one discharge make one hiccup cycle; hic_cnt_r counts them
	// the restart leaves the overcurrent count at zero, so a lasting overload
	// needs seven fresh cycles before hiccup comes back
	always_comb begin
		state_nxt = state_r;
		hic_cnt_nxt = hic_cnt_r;
		ss_cnt_nxt = ss_cnt_r;
		case (state_r)
			ohs_pkg::OHS_ST_RUN: begin
				if (trip) begin
					state_nxt = ohs_pkg::OHS_ST_CHARGE;
					hic_cnt_nxt = '0;
					ss_cnt_nxt = '0;
				end
			end
			ohs_pkg::OHS_ST_CHARGE: begin
				if (ss_done_chg) begin
					state_nxt = ohs_pkg::OHS_ST_DISCHARGE;
					ss_cnt_nxt = '0;
				end else if (pwm_cycle_en) begin
					ss_cnt_nxt = ss_cnt_r + CW'(1);
				end
			end
			ohs_pkg::OHS_ST_DISCHARGE: begin
				if (ss_done_dis) begin
					ss_cnt_nxt = '0;
					if (last_hiccup) begin
						state_nxt = ohs_pkg::OHS_ST_RUN;
						hic_cnt_nxt = '0;
					end else begin
						state_nxt = ohs_pkg::OHS_ST_CHARGE;
						hic_cnt_nxt = hic_cnt_r + CW'(1);
					end
				end else if (pwm_cycle_en) begin
					ss_cnt_nxt = ss_cnt_r + CW'(1);
				end
			end
			default: begin
				// an illegal state falls back to run with the counters cleared
				state_nxt = ohs_pkg::OHS_ST_RUN;
				hic_cnt_nxt = '0;
				ss_cnt_nxt = '0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// pulse termination and drive
	// ------------------------------------------------------------
	// the cut holds until the next cycle boundary so the pulse is not re-armed
	always_comb begin
		pulse_cut_nxt = pulse_cut_r;
		if (pwm_cycle_en) begin
			pulse_cut_nxt = 1'b0;
		end
		if (sense.over_limit) begin
			pulse_cut_nxt = 1'b1;
		end
	end

	// drives are registered from the next state so that they turn with hiccup_active
	wire logic switching = (state_nxt == ohs_pkg::OHS_ST_RUN);
	wire logic next_charge = (state_nxt == ohs_pkg::OHS_ST_CHARGE);
	wire logic next_discharge = (state_nxt == ohs_pkg::OHS_ST_DISCHARGE);
	wire logic on_ok = pwm_on && !pulse_cut_nxt && !sense.over_limit;

	always_comb begin
		drive_nxt.hi_drive = switching && on_ok;
		drive_nxt.lo_drive = switching && !on_ok;
		drive_nxt.ss_charge = next_charge;
		drive_nxt.ss_discharge = next_discharge;
	end

	// ------------------------------------------------------------
	// status flags
	// ------------------------------------------------------------
	// a masked track pin hides undervoltage and keeps power good low
	wire logic uv_seen = sense.undervolt && !sense.track_masked;
	// power good waits for the restart so it never shows during hiccup
	wire logic pg_seen = switching && sense.in_regulation && !sense.track_masked;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// sequence state and counters
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_r <= ohs_pkg::OHS_ST_RUN;
			oc_cnt_r <= '0;
			hic_cnt_r <= '0;
			ss_cnt_r <= '0;
		end else begin
			state_r <= state_nxt;
			oc_cnt_r <= oc_cnt_nxt;
			hic_cnt_r <= hic_cnt_nxt;
			ss_cnt_r <= ss_cnt_nxt;
		end
	end

	// cut latch, switch drives and soft-start drives
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pulse_cut_r <= 1'b0;
			drive_r <= '0;
		end else begin
			pulse_cut_r <= pulse_cut_nxt;
			drive_r <= drive_nxt;
		end
	end

	// status outputs
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pg_r <= 1'b0;
			uv_r <= 1'b0;
			entry_r <= 1'b0;
		end else begin
			uv_r <= uv_seen;
			pg_r <= pg_seen;
			entry_r <= trip;
		end
	end

	assign drive = drive_r;
	assign power_good_output = pg_r;
	assign uv_fault = uv_r;
	assign hiccup_active = !running;
	assign hiccup_entry = entry_r;
endmodule : ohs_sequencer

// File: dv/ohs_stage_model.sv
// Purpose: power stage and soft-start capacitor seen by the sequencer
// Assumes: overload and mask are set by the bench
// Notes: comparator levels only, no analog detail
`timescale 1ns/1ns
module ohs_stage_model (
	input wire logic ref_clk, // clock
	input wire ohs_pkg::ohs_drive_t drive, // drives from the block
	input wire logic overload, // load beyond the limit
	input wire logic masked, // track pin held low
	output ohs_pkg::ohs_sense_t sense_pin // comparator pins
);
	logic ss_busy_r;
	always_ff @(posedge ref_clk) ss_busy_r <= drive.ss_charge | drive.ss_discharge;
	// output sags under overload and while the capacitor is cycled
	assign sense_pin = '{over_limit: overload, track_masked: masked, undervolt: overload,
		in_regulation: !overload && !ss_busy_r};
endmodule : ohs_stage_model

// File: dv/ohs_sequencer_asserts.sv
// Purpose: port checks for the hiccup sequencer
// Assumes: sense pins settle within six clocks
// Notes: bound to ohs_sequencer
`timescale 1ns/1ns
module ohs_seq_asserts (
	input wire logic ref_clk, // clock
	input wire logic reset_n, // sync reset
	input wire logic pwm_cycle_en, // cycle mark
	input wire ohs_pkg::ohs_sense_t sense_pin, // pins
	input wire ohs_pkg::ohs_drive_t drive, // drives
	input wire logic power_good_output, // good flag
	input wire logic hiccup_active, // hiccup
	input wire logic hiccup_entry // entry pulse
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	a_drv_off: assert property (hiccup_active |-> !drive.hi_drive && !drive.lo_drive)
		else $error("drive on in hiccup");
	a_entry_cause: assert property (hiccup_entry |-> $rose(hiccup_active) && $past(pwm_cycle_en))
		else $error("entry without trip");
	a_rise_entry: assert property ($rose(hiccup_active) |-> hiccup_entry && drive.ss_charge)
		else $error("hiccup without entry");
	a_entry_single: assert property (hiccup_entry |=> !hiccup_entry)
		else $error("entry pulse too long");
	a_ss_onehot: assert property (hiccup_active |-> drive.ss_charge != drive.ss_discharge)
		else $error("soft-start phase wrong");
	a_exit_ss: assert property ($fell(hiccup_active) |-> !drive.ss_charge && !drive.ss_discharge)
		else $error("soft-start drive after exit");
	a_mask_quiet: assert property (sense_pin.track_masked [*6] |=> !hiccup_entry && !power_good_output)
		else $error("masked fault acted");
	a_oc_cut: assert property (sense_pin.over_limit [*6] |=> !drive.hi_drive)
		else $error("on-pulse not cut");
endmodule : ohs_seq_asserts
bind ohs_sequencer ohs_seq_asserts u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
	.pwm_cycle_en(pwm_cycle_en), .sense_pin(sense_pin), .drive(drive),
	.power_good_output(power_good_output), .hiccup_active(hiccup_active),
	.hiccup_entry(hiccup_entry));

// File: dv/tb_overcurrent_hiccup_sequencer.sv
// Purpose: scenario bench for the hiccup sequencer
// Assumes: switching period of eight clocks, soft-start phases of two cycles
// Notes: inputs change on falling edges
`timescale 1ns/1ns
module tb_overcurrent_hiccup_sequencer;
	logic ref_clk = 0, reset_n = 0, pwm_cycle_en = 0, pwm_on = 0, overload = 0, masked = 0;
	ohs_pkg::ohs_sense_t sense_pin;
	ohs_pkg::ohs_drive_t drive;
	logic power_good_output, uv_fault, hiccup_active, hiccup_entry;
	int bad_count = 0, comparisons = 0, ph = 0, n = 0, i = 0;
	initial forever #4 ref_clk = ~ref_clk;
	always @(negedge ref_clk) begin
		ph <= (ph + 1) % 8;
		pwm_cycle_en <= (ph == 7);
		pwm_on <= (ph < 3);
	end
	ohs_sequencer #(.CHG_PWM(2), .DIS_PWM(2)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
		.pwm_cycle_en(pwm_cycle_en), .pwm_on(pwm_on), .sense_pin(sense_pin), .drive(drive),
		.power_good_output(power_good_output), .uv_fault(uv_fault),
		.hiccup_active(hiccup_active), .hiccup_entry(hiccup_entry));
	ohs_stage_model stage (.ref_clk(ref_clk), .drive(drive), .overload(overload),
		.masked(masked), .sense_pin(sense_pin));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic per(input int k);
		repeat (k * 8) @(negedge ref_clk);
	endtask : per
	// counts whole periods until hiccup_active reaches lvl; bounded
	task automatic wait_hic(input logic lvl);
		n = 0;
		while (hiccup_active !== lvl && n < 60) begin
			per(1);
			n++;
		end
		if (hiccup_active !== lvl) begin
			chk(hiccup_active, lvl);
			final_report();
		end
	endtask : wait_hic
	task automatic final_report;
		if (bad_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	task automatic t_trip_and_hiccup;
		overload = 1;
		wait_hic(1);
		chk(n, ohs_pkg::OC_TRIP_CYCLES);
		wait_hic(0);
		chk(n, 28);
		wait_hic(1);
		chk(n, ohs_pkg::OC_TRIP_CYCLES);
		overload = 0;
		wait_hic(0);
		chk(n, 28);
		per(12);
		chk(hiccup_active, 0);
		chk(power_good_output, 1);
	endtask : t_trip_and_hiccup
	task automatic t_broken_run;
		for (i = 0; i < 13; i++) begin
			overload = (i != 6);
			per(1);
			chk(hiccup_active, 0);
		end
		overload = 0;
	endtask : t_broken_run
	task automatic t_masked;
		masked = 1;
		per(1);
		overload = 1;
		for (i = 0; i < 12; i++) begin
			per(1);
			chk(hiccup_active, 0);
			chk({power_good_output, uv_fault, drive.hi_drive}, 0);
		end
		overload = 0;
		masked = 0;
		per(2);
	endtask : t_masked
	initial begin
		repeat (20) @(negedge ref_clk);
		reset_n = 1;
		per(2);
		n = 0;
		while (pwm_cycle_en !== 1 && n < 8) begin
			@(negedge ref_clk);
			n++;
		end
		if (pwm_cycle_en !== 1) begin
			chk(pwm_cycle_en, 1);
			final_report();
		end
		@(negedge ref_clk);
		t_trip_and_hiccup();
		t_broken_run();
		t_masked();
		final_report();
	end
endmodule : tb_overcurrent_hiccup_sequencer
